// ### hdl/ext_irq_pkg.sv
// package for the external pin interrupt block: register map, field layout, sense codes, timing
// assumes a single 50 MHz clock and an AXI4-Lite master with 32-bit data
`default_nettype none
package ext_irq_pkg;
   // register byte offsets
   localparam logic [3:0] OFF_CONTROL = 4'h0; // mcu_control_reg
   localparam logic [3:0] OFF_STATUS  = 4'h4; // mcu_control_status_reg
   localparam logic [3:0] OFF_ENABLE  = 4'h8; // irq_enable_reg
   localparam logic [3:0] OFF_FLAG    = 4'hc; // irq_flag_reg
   localparam logic [3:0] OFF_GLOBAL  = 4'h0; // unused alias guard (not mapped)
   // field positions
   localparam int SENSE_A_LO_BIT = 0;
   localparam int SENSE_B_LO_BIT = 2;
   localparam int SENSE_C_BIT    = 6;
   localparam int EN_C_BIT       = 5;
   localparam int EN_A_BIT       = 6;
   localparam int EN_B_BIT       = 7;
   localparam int FLAG_C_BIT     = 5;
   localparam int FLAG_A_BIT     = 6;
   localparam int FLAG_B_BIT     = 7;
   localparam int GLOBAL_EN_BIT  = 0;
   localparam logic [3:0] OFF_GLOBAL_EN = 4'h0;
   // sense codes for pins a and b
   typedef enum logic [1:0] {SENSE_LOW, SENSE_ANY, SENSE_FALL, SENSE_RISE} sense_e;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // wake qualification: watchdog oscillator period and sampling count
   localparam int WDOG_PERIOD_NS = 1000;
   localparam int CLK_PERIOD_NS  = 20;
   localparam int WDOG_CYCLES    = (WDOG_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 : WDOG_PERIOD_NS / CLK_PERIOD_NS;
   localparam int WAKE_SAMPLES   = 2;
   // axi lite write request bundle
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } wr_req_s;
endpackage
`default_nettype wire

// ### hdl/external_pin_interrupts.sv
// external pin interrupt block: three pins, sense selection, pending flags, wake requests
// assumes AXI4-Lite master on clk; pin inputs synchronous; watchdog period counted on clk, sleep state from the system
//
// Overview of operation
// - pins detected even when driven as outputs
// - pins a,b: falling, rising or low level
// - pin c edge only, no level mode
// - low level requests while pin stays low
// - a,b edge detect needs running I/O clock
// - low level and pin c edge asynchronous
// - asynchronous detections wake from all sleeps
// - level wake needs two watchdog samples
// - wake on double sample or persisting level
// - level gone at start-up end: no interrupt
// - two-bit sense: low, any, fall, rise
// - pin c sense bit: 0 fall, 1 rise
// - edge flags set, cleared by service/write-one
// - request needs own and global enable
`default_nettype none
module external_pin_interrupts
   import ext_irq_pkg::*;
#(
   parameter int STARTUP_CYCLES = 64
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // pins, as seen at the pad including own output drive
   input  wire logic        extIrqPinA,
   input  wire logic        extIrqPinB,
   input  wire logic        extIrqPinC,
   // system side
   input  wire logic        ioClockRunning,
   input  wire logic        globalIrqEnable,
   input  wire logic        powerDown,
   input  wire logic        startupDone,
   input  wire logic [2:0]  irqServiced,
   output logic      [2:0]  irqRequest,
   output logic             wakeRequest,
   // axi4-lite slave
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready
);
   // start-up and watchdog counts share a 16-bit counter, so larger values cannot be served
   if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65536)
   begin
      $error("STARTUP_CYCLES must be between 1 and 65536");
   end

   typedef enum {WK_IDLE, WK_SAMPLE, WK_STARTUP} wake_e;

   // state
   logic [7:0]  controlReg, controlNext;
   logic        senseCReg, senseCNext;
   logic [2:0]  enableReg, enableNext;
   logic [2:0]  pendingReg, pendingNext;
   logic [2:0]  prevReg, prevNext;
   logic        prevCReg, prevCNext;
   logic        awHeldReg, awHeldNext, wHeldReg, wHeldNext;
   logic [3:0]  awAddrReg, awAddrNext;
   logic [31:0] wDataReg, wDataNext;
   logic        bvalidReg, bvalidNext, rvalidReg, rvalidNext;
   logic [1:0]  brespReg, brespNext, rrespReg, rrespNext;
   logic [31:0] rdataReg, rdataNext;
   wake_e       wakeReg, wakeNext;
   logic [15:0] tickReg, tickNext;
   logic [1:0]  sampleReg, sampleNext;
   logic [2:0]  levelQualReg, levelQualNext;
   logic        wakeOutReg, wakeOutNext;

   sense_e senseA, senseB;
   logic   edgeA, edgeB, edgeC, levelA, levelB, writeFire, readFire, anyLow;
   logic [2:0] flagWrite1;

   assign senseA = sense_e'(controlReg[SENSE_A_LO_BIT +: 2]);
   assign senseB = sense_e'(controlReg[SENSE_B_LO_BIT +: 2]);
   assign levelA = (senseA == SENSE_LOW);
   assign levelB = (senseB == SENSE_LOW);

   // transition match on current vs previous sample, only while io clock runs
   function automatic logic edgeMatch(sense_e s, logic cur, logic prev);
      edgeMatch = 1'b0;
      case (s)
         SENSE_ANY:  edgeMatch = cur ^ prev;
         SENSE_FALL: edgeMatch = prev & ~cur;
         SENSE_RISE: edgeMatch = cur & ~prev;
         default:    edgeMatch = 1'b0;
      endcase
   endfunction

   assign edgeA = ioClockRunning & edgeMatch(senseA, extIrqPinA, prevReg[0]);
   assign edgeB = ioClockRunning & edgeMatch(senseB, extIrqPinB, prevReg[1]);
   // pin c edge is kept without the io clock; only a fixed edge select exists
   assign edgeC = senseCReg ? (extIrqPinC & ~prevCReg) : (prevCReg & ~extIrqPinC);
   assign anyLow = (enableReg[0] & levelA & ~extIrqPinA) | (enableReg[1] & levelB & ~extIrqPinB);

   // bus handshakes
   assign awready   = ~awHeldReg & ~bvalidReg;
   assign wready    = ~wHeldReg & ~bvalidReg;
   assign writeFire = (awHeldReg | (awvalid & awready)) & (wHeldReg | (wvalid & wready)) & ~bvalidReg;
   assign arready   = ~rvalidReg;
   assign readFire  = arvalid & arready;

   // register file and flag next values
   always_comb
   begin
      logic [3:0]  wa;
      logic [31:0] wd;
      wa = awHeldReg ? awAddrReg : awaddr;
      wd = wHeldReg ? wDataReg : wdata;
      controlNext = controlReg;
      senseCNext  = senseCReg;
      enableNext  = enableReg;
      flagWrite1  = 3'h0;
      awHeldNext  = awHeldReg | (awvalid & awready);
      wHeldNext   = wHeldReg | (wvalid & wready);
      awAddrNext  = (awvalid & awready) ? awaddr : awAddrReg;
      wDataNext   = (wvalid & wready) ? wdata : wDataReg;
      bvalidNext  = bvalidReg & ~bready;
      brespNext   = brespReg;
      if (writeFire)
      begin
         awHeldNext = 1'b0;
         wHeldNext  = 1'b0;
         bvalidNext = 1'b1;
         brespNext  = RESP_OKAY;
         if (!wstrbOk(wHeldReg, wstrb)) begin end
         if (wa == OFF_CONTROL)
            controlNext = wd[7:0];
         else if (wa == OFF_STATUS)
            senseCNext = wd[SENSE_C_BIT];
         else if (wa == OFF_ENABLE)
            enableNext = {wd[EN_C_BIT], wd[EN_B_BIT], wd[EN_A_BIT]}; // index 0 = a, as on the read side
         else if (wa == OFF_FLAG)
            flagWrite1 = {wd[FLAG_C_BIT], wd[FLAG_B_BIT], wd[FLAG_A_BIT]};
         else
            brespNext = RESP_SLVERR;
      end
      // index 0 = a, 1 = b, 2 = c; set wins over clear
      pendingNext = (pendingReg & ~flagWrite1 & ~irqServiced) | {edgeC, edgeB, edgeA};
      if (levelA) pendingNext[0] = 1'b0;
      if (levelB) pendingNext[1] = 1'b0;
      prevNext  = {1'b0, extIrqPinB, extIrqPinA};
      prevCNext = extIrqPinC;
   end

   function automatic logic wstrbOk(logic held, logic [3:0] s);
      wstrbOk = held | (s != 4'h0);
   endfunction

   // read path
   always_comb
   begin
      rvalidNext = rvalidReg & ~rready;
      rdataNext  = rdataReg;
      rrespNext  = rrespReg;
      if (readFire)
      begin
         rvalidNext = 1'b1;
         rrespNext  = RESP_OKAY;
         rdataNext  = 32'h0;
         if (araddr == OFF_CONTROL)
            rdataNext[7:0] = controlReg;
         else if (araddr == OFF_STATUS)
            rdataNext[SENSE_C_BIT] = senseCReg;
         else if (araddr == OFF_ENABLE)
         begin
            rdataNext[EN_A_BIT] = enableReg[0];
            rdataNext[EN_B_BIT] = enableReg[1];
            rdataNext[EN_C_BIT] = enableReg[2];
         end
         else if (araddr == OFF_FLAG)
         begin
            rdataNext[FLAG_A_BIT] = pendingReg[0];
            rdataNext[FLAG_B_BIT] = pendingReg[1];
            rdataNext[FLAG_C_BIT] = pendingReg[2];
         end
         else
            rrespNext = RESP_SLVERR;
      end
   end

   // power-down level wake: two watchdog samples, then start-up window
   always_comb
   begin
      wakeNext      = wakeReg;
      tickNext      = tickReg;
      sampleNext    = sampleReg;
      levelQualNext = levelQualReg;
      wakeOutNext   = 1'b0;
      case (wakeReg)
         WK_IDLE:
         begin
            tickNext   = 16'h0;
            sampleNext = 2'h0;
            if (powerDown && anyLow)
               wakeNext = WK_SAMPLE;
            // pin c edge wakes at once from any sleep
            if (powerDown && enableReg[2] && edgeC)
               wakeOutNext = 1'b1;
         end
         WK_SAMPLE:
         begin
            if (!anyLow)
               wakeNext = WK_IDLE; // noise rejected
            else if (tickReg == 16'(WDOG_CYCLES - 1))
            begin
               tickNext   = 16'h0;
               sampleNext = sampleReg + 2'h1;
               if (sampleReg == 2'(WAKE_SAMPLES - 1))
               begin
                  wakeNext    = WK_STARTUP;
                  wakeOutNext = 1'b1;
               end
            end
            else
               tickNext = tickReg + 16'h1;
         end
         WK_STARTUP:
         begin
            wakeOutNext = 1'b1;
            if (startupDone || tickReg == 16'(STARTUP_CYCLES - 1))
            begin
               // level must still be there or no interrupt; relies on source holding it
               levelQualNext = {1'b0, levelB & ~extIrqPinB, levelA & ~extIrqPinA};
               wakeNext = WK_IDLE;
            end
            else
               tickNext = tickReg + 16'h1;
         end
         default: wakeNext = WK_IDLE;
      endcase
      if (!powerDown)
         levelQualNext = 3'h7;
   end

   // request outputs: level sources assert while low, edge sources from flags
   always_comb
   begin
      logic [2:0] src;
      src = pendingReg;
      if (levelA) src[0] = ~extIrqPinA & levelQualReg[0];
      if (levelB) src[1] = ~extIrqPinB & levelQualReg[1];
      irqRequest = src & enableReg & {3{globalIrqEnable}};
   end

   // registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         controlReg <= 8'h0; senseCReg <= 1'b0; enableReg <= 3'h0; pendingReg <= 3'h0;
         prevReg <= 3'h7; prevCReg <= 1'b1; awHeldReg <= 1'b0; wHeldReg <= 1'b0;
         awAddrReg <= 4'h0; wDataReg <= 32'h0; bvalidReg <= 1'b0; rvalidReg <= 1'b0;
         brespReg <= RESP_OKAY; rrespReg <= RESP_OKAY; rdataReg <= 32'h0;
         wakeReg <= WK_IDLE; tickReg <= 16'h0; sampleReg <= 2'h0; levelQualReg <= 3'h7; wakeOutReg <= 1'b0;
      end
      else
      begin
         controlReg <= controlNext; senseCReg <= senseCNext; enableReg <= enableNext; pendingReg <= pendingNext;
         prevReg <= prevNext; prevCReg <= prevCNext; awHeldReg <= awHeldNext; wHeldReg <= wHeldNext;
         awAddrReg <= awAddrNext; wDataReg <= wDataNext; bvalidReg <= bvalidNext; rvalidReg <= rvalidNext;
         brespReg <= brespNext; rrespReg <= rrespNext; rdataReg <= rdataNext;
         wakeReg <= wakeNext; tickReg <= tickNext; sampleReg <= sampleNext; levelQualReg <= levelQualNext;
         wakeOutReg <= wakeOutNext;
      end
   end

   assign wakeRequest = wakeOutReg;
   assign bvalid = bvalidReg;
   assign bresp  = brespReg;
   assign rvalid = rvalidReg;
   assign rresp  = rrespReg;
   assign rdata  = rdataReg;

   // checks
   fallEdgeA_a: assert property (@(posedge clk) disable iff (rst)
      (ioClockRunning && senseA == SENSE_FALL && prevReg[0] && !extIrqPinA) |=> pendingReg[0])
      else $error("falling edge on pin a not flagged");
   levelHoldsA_a: assert property (@(posedge clk) disable iff (rst)
      (levelA && !extIrqPinA && enableReg[0] && globalIrqEnable && levelQualReg[0]) |-> irqRequest[0])
      else $error("low level on pin a not requesting");
   noEdgeStopped_a: assert property (@(posedge clk) disable iff (rst)
      (!ioClockRunning && !pendingReg[0]) |=> !pendingReg[0])
      else $error("pin a edge seen with io clock stopped");
   pinCRise_a: assert property (@(posedge clk) disable iff (rst)
      (senseCReg && !prevCReg && extIrqPinC) |=> pendingReg[2])
      else $error("rising edge on pin c not flagged");
   levelClears_a: assert property (@(posedge clk) disable iff (rst)
      levelB |=> (!pendingReg[1] || !$past(levelB)))
      else $error("pin b flag set in level mode");
   gateEnable_a: assert property (@(posedge clk) disable iff (rst)
      !globalIrqEnable |-> irqRequest == 3'h0)
      else $error("request without global enable");
   sequence lowHeld2;
      (wakeReg == WK_SAMPLE && anyLow);
   endsequence
   twoSamples_a: assert property (@(posedge clk) disable iff (rst)
      (wakeReg == WK_IDLE && powerDown && anyLow && !edgeC) |=> !wakeRequest)
      else $error("wake before watchdog samples");
   wakeStays_a: assert property (@(posedge clk) disable iff (rst)
      ($rose(wakeReg == WK_STARTUP)) |-> wakeRequest)
      else $error("qualified level did not wake");
endmodule
`default_nettype wire

// ### verif/pin_source.sv
// partner model: three external sources driving the interrupt pads
// assumes the bench calls its task from the clk domain of the block
`default_nettype none
module pin_source
(
   // clock
   input  wire logic clk,
   // pads, idle high
   output var logic  pinA,
   output var logic  pinB,
   output var logic  pinC
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle level until a source is told to act
   initial
   begin
      pinA = 1'h1;
      pinB = 1'h1;
      pinC = 1'h1;
   end

   // one pad changes just after an edge; a low level stays until the caller lifts it,
   // so a level wake can run to completion before release
   task automatic drive(input int idx, input logic lvl);
      @(posedge clk);
      if (idx == 0) pinA <= lvl;
      else if (idx == 1) pinB <= lvl;
      else pinC <= lvl;
   endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench: bus master, bench model of flags and requests, pin sources
// assumes the block's own assertions guard the cycle relations
`default_nettype none
module tb
   import ext_irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'h0;
   logic        rst = 1'h1;
   logic        pinA, pinB, pinC, awready, wready, bvalid, arready, rvalid, wakeRequest;
   logic        ioClockRunning = 1'h1, globalIrqEnable = 1'h0, powerDown = 1'h0, startupDone = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [2:0]  irqServiced = 3'h0;
   logic [2:0]  irqRequest;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0]  bresp, rresp, rsp;
   int          err_count = 0, n_compared = 0, expFlag = 0, expEn = 0, tmp, n;

   always #10 clk = ~clk;

   external_pin_interrupts #(.STARTUP_CYCLES(4)) external_pin_interrupts_i (.clk(clk), .rst(rst),
      .extIrqPinA(pinA), .extIrqPinB(pinB), .extIrqPinC(pinC), .ioClockRunning(ioClockRunning),
      .globalIrqEnable(globalIrqEnable), .powerDown(powerDown), .startupDone(startupDone),
      .irqServiced(irqServiced), .irqRequest(irqRequest), .wakeRequest(wakeRequest),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   pin_source pin_source_i (.clk(clk), .pinA(pinA), .pinB(pinB), .pinC(pinC));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge clk);
   endtask

   // write: address and data offered together, each dropped when taken
   task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid === 1'h1) break;
      end
      rsp = bresp;
      bready <= 1'h0;
      check("write answered", 32'(n < 100), 32'h1);
   endtask

   task automatic axiRead(input logic [3:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid === 1'h1) break;
      end
      rd = rdata;
      rsp = rresp;
      rready <= 1'h0;
      check("read answered", 32'(n < 100), 32'h1);
   endtask

   function automatic int fb(input int p);
      return (p == 0) ? FLAG_A_BIT : ((p == 1) ? FLAG_B_BIT : FLAG_C_BIT);
   endfunction

   // flags against the model, and requests as flag, own enable and global enable
   task automatic chkFlags(input string what);
      logic [2:0] e;
      // expectation built after the read, so a global enable changed just before has landed
      axiRead(OFF_FLAG);
      e = 3'h0;
      for (int p = 0; p < 3; p++)
         e[p] = globalIrqEnable && expFlag[fb(p)] && expEn[fb(p)];
      check({what, " flags"}, rd & 32'he0, 32'(expFlag));
      check({what, " request"}, 32'(irqRequest), 32'(e));
   endtask

   task automatic clearAll();
      axiWrite(OFF_FLAG, 32'he0);
      expFlag = 0;
   endtask

   // hang guard, far beyond the expected run of a few hundred cycles
   initial
   begin
      #(20 * 20000);
      err_count++;
      stop_test();
   end

   initial
   begin
      tmp = $urandom(65555);
      tick(3);
      rst <= 1'h0;
      for (int i = 0; i < 4; i++)
      begin
         axiRead(4'(4 * i));
         check("reset value", rd, 32'h0);
         check("read resp", 32'(rsp), 32'(RESP_OKAY));
      end
      axiRead(4'h2);
      check("unmapped resp", 32'(rsp), 32'(RESP_SLVERR));
      axiWrite(4'h6, 32'hff);
      check("unmapped write", 32'(rsp), 32'(RESP_SLVERR));
      tmp = $urandom;
      axiWrite(OFF_CONTROL, 32'(tmp));
      axiRead(OFF_CONTROL);
      check("sense fields", rd & 32'hf, 32'(tmp) & 32'hf);
      // random enable pattern read back, each bit must land in its own place
      axiWrite(OFF_ENABLE, 32'(tmp) & 32'he0);
      axiRead(OFF_ENABLE);
      check("enable fields", rd, 32'(tmp) & 32'he0);
      axiWrite(OFF_ENABLE, 32'he0);
      expEn = 32'he0;
      globalIrqEnable <= 1'h1;
      // every edge code on both level-capable pins, fall then rise
      for (int p = 0; p < 2; p++)
         for (int c = 1; c < 4; c++)
         begin
            axiWrite(OFF_CONTROL, 32'(c << (2 * p)));
            clearAll();
            pin_source_i.drive(p, 1'h0);
            tick(4);
            if (c != SENSE_RISE) expFlag[fb(p)] = 1;
            chkFlags("fall");
            pin_source_i.drive(p, 1'h1);
            tick(4);
            if (c != SENSE_FALL) expFlag[fb(p)] = 1;
            chkFlags("rise");
         end
      axiWrite(OFF_FLAG, 32'h1 << FLAG_B_BIT);
      expFlag[FLAG_B_BIT] = 0;
      chkFlags("write one");
      // low level: request lasts while low, flag stays clear
      axiWrite(OFF_CONTROL, 32'h0);
      clearAll();
      pin_source_i.drive(0, 1'h0);
      tick(25);
      check("level request", 32'(irqRequest[0]), 32'h1);
      axiRead(OFF_FLAG);
      check("level flag", rd & 32'he0, 32'h0);
      pin_source_i.drive(0, 1'h1);
      tick(3);
      check("level release", 32'(irqRequest[0]), 32'h0);
      // stopped i/o clock: pin a edge unseen, pin c edge still caught
      axiWrite(OFF_CONTROL, 32'(SENSE_FALL));
      clearAll();
      ioClockRunning <= 1'h0;
      pin_source_i.drive(0, 1'h0);
      pin_source_i.drive(2, 1'h0);
      tick(4);
      expFlag[FLAG_C_BIT] = 1;
      chkFlags("clock stopped");
      pin_source_i.drive(0, 1'h1);
      ioClockRunning <= 1'h1;
      axiWrite(OFF_STATUS, 32'h1 << SENSE_C_BIT);
      clearAll();
      tick(20);
      chkFlags("c held low");
      pin_source_i.drive(2, 1'h1);
      tick(4);
      expFlag[FLAG_C_BIT] = 1;
      chkFlags("c rise");
      globalIrqEnable <= 1'h0;
      chkFlags("global off");
      globalIrqEnable <= 1'h1;
      irqServiced <= 3'h4;
      @(posedge clk);
      irqServiced <= 3'h0;
      expFlag[FLAG_C_BIT] = 0;
      tick(2);
      chkFlags("serviced");
      // level wake from power-down after double sampling
      axiWrite(OFF_CONTROL, 32'h0);
      powerDown <= 1'h1;
      pin_source_i.drive(0, 1'h0);
      tick(20);
      check("early wake", 32'(wakeRequest), 32'h0);
      for (n = 0; n < 300 && wakeRequest !== 1'h1; n++) @(posedge clk);
      check("level wake", 32'(wakeRequest), 32'h1);
      startupDone <= 1'h1;
      @(posedge clk);
      startupDone <= 1'h0;
      pin_source_i.drive(0, 1'h1);
      powerDown <= 1'h0;
      tick(5);
      powerDown <= 1'h1;
      pin_source_i.drive(2, 1'h0);
      pin_source_i.drive(2, 1'h1);
      for (n = 0; n < 10 && wakeRequest !== 1'h1; n++) @(posedge clk);
      check("edge wake", 32'(wakeRequest), 32'h1);
      powerDown <= 1'h0;
      tick(5);
      stop_test();
   end
endmodule
`default_nettype wire
